// >>> hdl/rtcam_top.sv
// Clockwatch with alarm compare and load registers behind an AXI4-Lite slave.
// Assumes one clock, synchronous reset, and a leap-year level from same-clock logic.
//
// How it works
// - Seconds alarm 0..59 compared, 60..63 never
// - Minutes alarm 0..59 compared, 60..63 never
// - Hours alarm 0..23 compared, 24..31 never
// - Weekday alarm zero means ignore weekday
// - Day-of-month alarm zero means ignore day
// - Month alarm 1..12, zero ignores, 13..15 never
// - All alarm fields read zero after reset
// - Weekday Sunday 1 to Saturday 7, zero only if loaded, then steps to 1
// - Month January 1 to December 12
// - Match raises sticky event until cleared by one
// - Running time shares alarm field positions
//
// Decided for this implementation: the AXI4-Lite register port.
`default_nettype none
module rtcam_top
	import rtcam_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES                 // System cycles per second
) (
	input  wire logic        I_CLK,
	input  wire logic        I_SYS_RST,
	input  wire logic        I_LEAP_YEAR,                // Current year is a leap year
	input  wire logic [7:0]  I_AWADDR,
	input  wire logic        I_AWVALID,
	output logic             O_AWREADY,
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0]  I_WSTRB,
	input  wire logic        I_WVALID,
	output logic             O_WREADY,
	output logic [1:0]       O_BRESP,
	output logic             O_BVALID,
	input  wire logic        I_BREADY,
	input  wire logic [7:0]  I_ARADDR,
	input  wire logic        I_ARVALID,
	output logic             O_ARREADY,
	output logic [31:0]      O_RDATA,
	output logic [1:0]       O_RRESP,
	output logic             O_RVALID,
	input  wire logic        I_RREADY,
	output logic             O_ALARM_MATCH,              // One-cycle pulse on each hit
	output logic             O_IRQ                       // Level, enabled event pending
);
	// Refuse a divider too short to leave a gap between ticks
	if (TICK_DIV < 2) begin
		$error("TICK_DIV must be at least 2");
	end

	// Days in a month, leap February gets 29
	function automatic logic [4:0] month_len(input logic [3:0] mo, input logic leap);
		logic [4:0] len;
		len = LEN_31;
		if (mo == MO_FEB) len = leap ? LEN_29 : LEN_28;
		else if (mo == MO_APR || mo == MO_JUN || mo == MO_SEP || mo == MO_NOV) len = LEN_30;
		return len;
	endfunction

	// One second forward with all carries
	function automatic logic [28:0] advance(input logic [28:0] t, input logic leap);
		logic [5:0] s;
		logic [5:0] m;
		logic [4:0] h;
		logic [2:0] w;
		logic [4:0] d;
		logic [3:0] mo;
		s  = t[SEC_LO +: SEC_W];
		m  = t[MIN_LO +: MIN_W];
		h  = t[HR_LO +: HR_W];
		w  = t[WD_LO +: WD_W];
		d  = t[MD_LO +: MD_W];
		mo = t[MO_LO +: MO_W];
		if (s < SEC_MAX) s = s + 6'h01;
		else begin
			s = 6'h00;
			if (m < MIN_MAX) m = m + 6'h01;
			else begin
				m = 6'h00;
				if (h < HR_MAX) h = h + 5'h01;
				else begin
					h = 5'h00;
					w = (w >= WD_MAX) ? WD_MIN : w + 3'h1;
					if (d < month_len(mo, leap)) d = d + 5'h01;
					else begin
						d  = MD_MIN;
						mo = (mo >= MO_MAX) ? MO_MIN : mo + 4'h1;
					end
				end
			end
		end
		return {mo, d, w, h, m, s};
	endfunction

	// Alarm hit test of running time against alarm value
	function automatic logic alarm_hit(input logic [28:0] t, input logic [28:0] a);
		logic ok;
		ok = (a[SEC_LO +: SEC_W] <= SEC_MAX) && (a[SEC_LO +: SEC_W] == t[SEC_LO +: SEC_W]);
		ok = ok && (a[MIN_LO +: MIN_W] <= MIN_MAX)
			&& (a[MIN_LO +: MIN_W] == t[MIN_LO +: MIN_W]);
		ok = ok && (a[HR_LO +: HR_W] <= HR_MAX) && (a[HR_LO +: HR_W] == t[HR_LO +: HR_W]);
		ok = ok && (a[WD_LO +: WD_W] == 3'h0 || a[WD_LO +: WD_W] == t[WD_LO +: WD_W]);
		ok = ok && (a[MD_LO +: MD_W] == 5'h00 || a[MD_LO +: MD_W] == t[MD_LO +: MD_W]);
		ok = ok && (a[MO_LO +: MO_W] <= MO_MAX)
			&& (a[MO_LO +: MO_W] == 4'h0 || a[MO_LO +: MO_W] == t[MO_LO +: MO_W]);
		return ok;
	endfunction

	// Apply byte strobes to a stored word, reserved bits dropped
	function automatic logic [28:0] merge(input logic [28:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		logic [31:0] r;
		r = {3'h0, old};
		for (int i = 0; i < 4; i++) begin
			if (st[i]) r[8*i +: 8] = wd[8*i +: 8];
		end
		return r[DT_W-1:0];
	endfunction

	logic [28:0] run_dt;                                  // Running date/time
	logic [28:0] alarm_dt;                                // Alarm compare value
	logic [28:0] load_dt;                                 // Last written load value
	logic        stat;                                    // Sticky alarm event
	logic        ien;                                     // Interrupt enable
	logic        updated;                                 // Running time changed last cycle
	logic [31:0] tick_cnt;                                // Second divider
	logic        aw_got;                                  // Write address held
	logic        w_got;                                   // Write data held
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// Decoding of the held write and of the read address
	wire        tick      = (tick_cnt == 32'(TICK_DIV - 1));
	wire        wr_go     = aw_got && w_got && !O_BVALID;
	wire        wr_alarm  = wr_go && (aw_addr == RTCAM_OFS_ALARM);
	wire        wr_load   = wr_go && (aw_addr == RTCAM_OFS_LOAD);
	wire        wr_ien    = wr_go && (aw_addr == RTCAM_OFS_IEN);
	wire        wr_clr    = wr_go && (aw_addr == RTCAM_OFS_ICLR) && w_strb[0] && w_data[0];
	wire        wr_known  = (aw_addr == RTCAM_OFS_RUN) || (aw_addr == RTCAM_OFS_ALARM)
		|| (aw_addr == RTCAM_OFS_LOAD) || (aw_addr == RTCAM_OFS_STAT)
		|| (aw_addr == RTCAM_OFS_IEN) || (aw_addr == RTCAM_OFS_ICLR);
	wire        rd_go     = I_ARVALID && O_ARREADY;
	wire        rd_known  = (I_ARADDR == RTCAM_OFS_RUN) || (I_ARADDR == RTCAM_OFS_ALARM)
		|| (I_ARADDR == RTCAM_OFS_LOAD) || (I_ARADDR == RTCAM_OFS_STAT)
		|| (I_ARADDR == RTCAM_OFS_IEN) || (I_ARADDR == RTCAM_OFS_ICLR);
	wire [28:0] rd_word   = (I_ARADDR == RTCAM_OFS_RUN)   ? run_dt
		: (I_ARADDR == RTCAM_OFS_ALARM) ? alarm_dt
		: (I_ARADDR == RTCAM_OFS_LOAD)  ? load_dt
		: (I_ARADDR == RTCAM_OFS_STAT)  ? {28'h0, stat}
		: (I_ARADDR == RTCAM_OFS_IEN)   ? {28'h0, ien} : 29'h0;
	wire        hit       = updated && alarm_hit(run_dt, alarm_dt);
	wire        next_stat = hit || (stat && !wr_clr);     // Set wins over clear
	wire [28:0] next_load = merge(load_dt, w_data, w_strb); // Held word, strobed bytes only
	wire        next_ien  = (wr_ien && w_strb[0]) ? w_data[0] : ien; // Enable after this edge

	// Second divider
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST || tick) tick_cnt <= 32'h0;
		else tick_cnt <= tick_cnt + 32'h1;
	end

	// Running clockwatch; a load write takes priority over the tick
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			run_dt  <= RUN_RST;
			updated <= 1'b0;
		end else begin
			if (wr_load) run_dt <= next_load;
			else if (tick) run_dt <= advance(run_dt, I_LEAP_YEAR);
			updated <= wr_load || tick;
		end
	end

	// Software-written registers
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			alarm_dt <= ALARM_RST;
			load_dt  <= LOAD_RST;
			ien      <= 1'b0;
		end else begin
			if (wr_alarm) alarm_dt <= merge(alarm_dt, w_data, w_strb);
			if (wr_load) load_dt <= next_load;
			ien <= next_ien;
		end
	end

	// Sticky event, interrupt and match pulse
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			stat          <= 1'b0;
			O_IRQ         <= 1'b0;
			O_ALARM_MATCH <= 1'b0;
		end else begin
			stat          <= next_stat;
			O_IRQ         <= next_stat && next_ien;
			O_ALARM_MATCH <= hit;
		end
	end

	// Write channels: address and data in either order, then response
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			aw_got    <= 1'b0;
			w_got     <= 1'b0;
			aw_addr   <= 8'h00;
			w_data    <= 32'h0;
			w_strb    <= 4'h0;
			O_AWREADY <= 1'b1;
			O_WREADY  <= 1'b1;
			O_BVALID  <= 1'b0;
			O_BRESP   <= RESP_OKAY;
		end else begin
			if (I_AWVALID && O_AWREADY) begin
				aw_got    <= 1'b1;
				aw_addr   <= I_AWADDR;
				O_AWREADY <= 1'b0;
			end
			if (I_WVALID && O_WREADY) begin
				w_got    <= 1'b1;
				w_data   <= I_WDATA;
				w_strb   <= I_WSTRB;
				O_WREADY <= 1'b0;
			end
			if (wr_go) begin
				aw_got   <= 1'b0;
				w_got    <= 1'b0;
				O_BVALID <= 1'b1;
				O_BRESP  <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end
			if (O_BVALID && I_BREADY) begin
				O_BVALID  <= 1'b0;
				O_AWREADY <= 1'b1;
				O_WREADY  <= 1'b1;
			end
		end
	end

	// Read channel: one cycle from address to data
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_ARREADY <= 1'b1;
			O_RVALID  <= 1'b0;
			O_RDATA   <= 32'h0;
			O_RRESP   <= RESP_OKAY;
		end else if (rd_go) begin
			O_ARREADY <= 1'b0;
			O_RVALID  <= 1'b1;
			O_RDATA   <= {3'h0, rd_word};
			O_RRESP   <= rd_known ? RESP_OKAY : RESP_SLVERR;
		end else if (O_RVALID && I_RREADY) begin
			O_RVALID  <= 1'b0;
			O_ARREADY <= 1'b1;
		end
	end

	// Checks
	sec_never_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		alarm_dt[SEC_LO +: SEC_W] > SEC_MAX |=> !O_ALARM_MATCH)
		else $error("match with invalid seconds alarm");
	min_never_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		alarm_dt[MIN_LO +: MIN_W] > MIN_MAX |=> !O_ALARM_MATCH)
		else $error("match with invalid minutes alarm");
	hour_never_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		alarm_dt[HR_LO +: HR_W] > HR_MAX |=> !O_ALARM_MATCH)
		else $error("match with invalid hours alarm");
	wday_ignore_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		O_ALARM_MATCH && $past(alarm_dt[WD_LO +: WD_W]) != 3'h0
		|-> $past(alarm_dt[WD_LO +: WD_W]) == $past(run_dt[WD_LO +: WD_W]))
		else $error("weekday mismatch yet matched");
	mday_ignore_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		O_ALARM_MATCH && $past(alarm_dt[MD_LO +: MD_W]) != 5'h00
		|-> $past(alarm_dt[MD_LO +: MD_W]) == $past(run_dt[MD_LO +: MD_W]))
		else $error("day of month mismatch yet matched");
	irq_level_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		O_IRQ == (stat && ien))
		else $error("interrupt level differs from enabled event");
	month_never_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		alarm_dt[MO_LO +: MO_W] > MO_MAX |=> !O_ALARM_MATCH)
		else $error("match with invalid month alarm");
	alarm_reset_a: assert property (@(posedge I_CLK)
		$past(I_SYS_RST) |-> alarm_dt == 29'h0)
		else $error("alarm not zero after reset");
	event_sticky_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		stat && !wr_clr |=> stat)
		else $error("event lost without clear");
	hit_sets_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		O_ALARM_MATCH |-> stat)
		else $error("hit did not set event");
	load_copy_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		wr_load |=> run_dt == load_dt)
		else $error("load not copied to running time");
	rsvd_zero_a: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
		O_RVALID |-> O_RDATA[31:29] == 3'h0)
		else $error("reserved bits not zero");
	cover_match_c: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) O_ALARM_MATCH);
	cover_clear_c: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) stat ##1 !stat);
	cover_load_c:  cover property (@(posedge I_CLK) disable iff (I_SYS_RST) wr_load);
	cover_irq_c:   cover property (@(posedge I_CLK) disable iff (I_SYS_RST) O_IRQ);
endmodule
`default_nettype wire

// >>> hdl/rtcam_pkg.sv
// Package of the clockwatch alarm and load block: map, fields, timing.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
`default_nettype none
package rtcam_pkg;
	// Register byte offsets
	localparam logic [7:0] RTCAM_OFS_RUN   = 8'h00; // Running date/time, read only
	localparam logic [7:0] RTCAM_OFS_ALARM = 8'h04; // Alarm compare values
	localparam logic [7:0] RTCAM_OFS_LOAD  = 8'h08; // Load values, write copies in
	localparam logic [7:0] RTCAM_OFS_STAT  = 8'h0C; // Sticky event status, read only
	localparam logic [7:0] RTCAM_OFS_IEN   = 8'h10; // Interrupt enable
	localparam logic [7:0] RTCAM_OFS_ICLR  = 8'h14; // Write one to clear, reads zero
	// Field positions (low bit and width)
	localparam int SEC_LO = 0;
	localparam int SEC_W  = 6;
	localparam int MIN_LO = 6;
	localparam int MIN_W  = 6;
	localparam int HR_LO  = 12;
	localparam int HR_W   = 5;
	localparam int WD_LO  = 17;
	localparam int WD_W   = 3;
	localparam int MD_LO  = 20;
	localparam int MD_W   = 5;
	localparam int MO_LO  = 25;
	localparam int MO_W   = 4;
	localparam int DT_W   = 29;                          // Bits 31:29 reserved
	// Field limits
	localparam logic [5:0] SEC_MAX = 6'h3B;
	localparam logic [5:0] MIN_MAX = 6'h3B;
	localparam logic [4:0] HR_MAX  = 5'h17;
	localparam logic [2:0] WD_MAX  = 3'h7;
	localparam logic [2:0] WD_MIN  = 3'h1;
	localparam logic [4:0] MD_MIN  = 5'h01;
	localparam logic [3:0] MO_MAX  = 4'hC;
	localparam logic [3:0] MO_MIN  = 4'h1;
	localparam logic [3:0] MO_FEB  = 4'h2;
	localparam logic [3:0] MO_APR  = 4'h4;
	localparam logic [3:0] MO_JUN  = 4'h6;
	localparam logic [3:0] MO_SEP  = 4'h9;
	localparam logic [3:0] MO_NOV  = 4'hB;
	localparam logic [4:0] LEN_28  = 5'h1C;
	localparam logic [4:0] LEN_29  = 5'h1D;
	localparam logic [4:0] LEN_30  = 5'h1E;
	localparam logic [4:0] LEN_31  = 5'h1F;
	// Reset values
	localparam logic [28:0] RUN_RST   = 29'h02120000;    // 1 January, Sunday, 00:00:00
	localparam logic [28:0] ALARM_RST = 29'h00000000;
	localparam logic [28:0] LOAD_RST  = 29'h00000000;
	// Response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Timing
	localparam longint CLK_FREQ_HZ    = 50_000_000;
	localparam longint TICK_PERIOD_MS = 1000;
	localparam int     TICK_CYCLES    = int'(CLK_FREQ_HZ * TICK_PERIOD_MS / 1000);
endpackage
`default_nettype wire

// >>> testbench/test_clockwatch_alarm_match_load.sv
// Self-checking bench of the clockwatch alarm and load block over AXI4-Lite.
// Assumes the block shortened to ten system cycles per second; one clock, 50 MHz.
`default_nettype none
module test_clockwatch_alarm_match_load
	import rtcam_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// One table row: alarm word, load word, leap level, expected hit count
	typedef struct {logic [31:0] alarm; logic [31:0] load;
		logic leap; logic [31:0] hits;} rtcam_row_t;
	localparam int DIV = 10;                 // Short second for simulation
	logic        clk, sys_rst, leap;         // Clock, reset, leap-year level
	logic [7:0]  awaddr, araddr;             // Bus addresses
	logic        awvalid, wvalid, bready;    // Write channel controls
	logic        arvalid, rready;            // Read channel controls
	logic [31:0] wdata;                      // Write data
	logic [3:0]  wstrb;                      // Write byte strobes
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0]  o_bresp, o_rresp;           // Response codes
	logic [31:0] o_rdata;                    // Read data
	logic        o_match, o_irq;             // Alarm pulse and interrupt level
	int          fail_count, checked, hits;  // Counters
	logic [31:0] d;                          // Read-back word
	logic [1:0]  r;                          // Read-back response
	rtcam_row_t  rows [14];                  // Ordinary cases
	// Design under test
	rtcam_top #(.TICK_DIV(DIV)) DUT (.I_CLK(clk), .I_SYS_RST(sys_rst), .I_LEAP_YEAR(leap),
		.I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(o_awready), .I_WDATA(wdata),
		.I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(o_wready), .O_BRESP(o_bresp),
		.O_BVALID(o_bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
		.O_ARREADY(o_arready), .O_RDATA(o_rdata), .O_RRESP(o_rresp), .O_RVALID(o_rvalid),
		.I_RREADY(rready), .O_ALARM_MATCH(o_match), .O_IRQ(o_irq));
	// Clock, 20 ns period
	always #10 clk = ~clk;
	// Count alarm pulses seen
	always @(posedge clk) begin
		if (o_match === 1'b1) hits <= hits + 1;
	end
	// Pack the six date/time fields at their shared positions
	function automatic logic [31:0] dt(int s, int mi, int h, int w, int md, int mo);
		return (32'(s) << SEC_LO) | (32'(mi) << MIN_LO) | (32'(h) << HR_LO)
			| (32'(w) << WD_LO) | (32'(md) << MD_LO) | (32'(mo) << MO_LO);
	endfunction
	// Compare one value and count it
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One AXI4-Lite write; address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		int n;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (awvalid && o_awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && o_wready === 1'b1) wvalid <= 1'b0;
		end while (!(bready && o_bvalid === 1'b1) && n < 50);
		resp = o_bresp;
		bready <= 1'b0;
		if (n >= 50) fail_count++;
	endtask
	// One AXI4-Lite read; ready held until the answer is sampled
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (arvalid && o_arready === 1'b1) arvalid <= 1'b0;
		end while (!(rready && o_rvalid === 1'b1) && n < 50);
		v = o_rdata;
		resp = o_rresp;
		rready <= 1'b0;
		if (n >= 50) fail_count++;
	endtask
	// Counts, verdict, end of run
	task automatic complete_run();
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		repeat (6000) @(posedge clk);
		fail_count++;
		complete_run();
	end
	// Main sequence
	initial begin
		int base;
		clk = 1'b0;
		{sys_rst, leap, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
		sys_rst = 1'b1;
		wdata = '0;
		wstrb = 4'hF;
		{fail_count, checked, hits} = '0;
		// Alarm 12:34:56, load one second earlier, Tuesday 15 June
		rows = '{'{dt(56,34,12,0,0,0), dt(55,34,12,3,15,6), 1'b0, 1},
			'{dt(60,34,12,0,0,0), dt(59,34,12,3,15,6), 1'b0, 0},
			'{dt(56,60,12,0,0,0), dt(55,34,12,3,15,6), 1'b0, 0},
			'{dt(56,34,24,0,0,0), dt(55,34,12,3,15,6), 1'b0, 0},
			'{dt(56,34,12,3,0,0), dt(55,34,12,3,15,6), 1'b0, 1},
			'{dt(56,34,12,4,0,0), dt(55,34,12,3,15,6), 1'b0, 0},
			'{dt(56,34,12,0,15,0), dt(55,34,12,3,15,6), 1'b0, 1},
			'{dt(56,34,12,0,16,0), dt(55,34,12,3,15,6), 1'b0, 0},
			'{dt(56,34,12,0,0,6), dt(55,34,12,3,15,6), 1'b0, 1},
			'{dt(56,34,12,0,0,7), dt(55,34,12,3,15,6), 1'b0, 0},
			'{dt(56,34,12,0,0,13), dt(55,34,12,3,15,6), 1'b0, 0},
			'{dt(56,34,12,3,15,6), dt(55,34,12,3,15,6), 1'b0, 1},
			'{dt(0,0,0,0,29,2), dt(59,59,23,5,28,2), 1'b1, 1},
			'{dt(0,0,0,0,29,2), dt(59,59,23,5,28,2), 1'b0, 0}};
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		// Reset values and the map edges
		rd(RTCAM_OFS_ALARM, d, r);
		chk("alarm after reset", d, 32'h0);
		rd(RTCAM_OFS_LOAD, d, r);
		chk("load after reset", d, 32'h0);
		rd(RTCAM_OFS_RUN, d, r);
		chk("running after reset", d, {3'h0, RUN_RST});
		rd(8'h18, d, r);
		chk("unmapped read resp", 32'(r), 32'(RESP_SLVERR));
		chk("unmapped read data", d, 32'h0);
		wr(RTCAM_OFS_ALARM, 32'hFFFFFFFF, r);
		chk("alarm write resp", 32'(r), 32'(RESP_OKAY));
		rd(RTCAM_OFS_ALARM, d, r);
		chk("alarm top bits", d, 32'h1FFFFFFF);
		// Low byte only: the other bytes keep their invalid codes
		wstrb <= 4'h1;
		wr(RTCAM_OFS_ALARM, 32'h0, r);
		wstrb <= 4'hF;
		rd(RTCAM_OFS_ALARM, d, r);
		chk("alarm byte strobe", d, 32'h1FFFFF00);
		wr(8'h18, 32'h0, r);
		chk("unmapped write resp", 32'(r), 32'(RESP_SLVERR));
		$display("done: reset and map");
		// Table: program alarm, load a second before, count hits over two and a half seconds
		foreach (rows[i]) begin
			leap <= rows[i].leap;
			wr(RTCAM_OFS_ALARM, rows[i].alarm, r);
			wr(RTCAM_OFS_LOAD, rows[i].load, r);
			base = hits;
			repeat (2 * DIV + 5) @(posedge clk);
			chk("alarm hits", 32'(hits - base), rows[i].hits);
			rd(RTCAM_OFS_ALARM, d, r);
			chk("alarm readback", d, rows[i].alarm);
			rd(RTCAM_OFS_LOAD, d, r);
			chk("load readback", d, rows[i].load);
		end
		$display("done: alarm table");
		// Sticky event, masked, enabled, then cleared
		chk("irq masked", 32'(o_irq), 32'h0);
		rd(RTCAM_OFS_STAT, d, r);
		chk("status sticky", d, 32'h1);
		wr(RTCAM_OFS_IEN, 32'h1, r);
		repeat (2) @(posedge clk);
		chk("irq enabled", 32'(o_irq), 32'h1);
		wr(RTCAM_OFS_ICLR, 32'h1, r);
		rd(RTCAM_OFS_STAT, d, r);
		chk("status cleared", d, 32'h0);
		chk("irq cleared", 32'(o_irq), 32'h0);
		$display("done: interrupt");
		// Second reset in mid-run
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(RTCAM_OFS_ALARM, d, r);
		chk("alarm after second reset", d, 32'h0);
		rd(RTCAM_OFS_RUN, d, r);
		chk("running after second reset", d, {3'h0, RUN_RST});
		$display("done: second reset");
		complete_run();
	end
endmodule
`default_nettype wire
